//--- rtl/alx_pkg.sv
/*
 * package for the add/and execution datapath: opcode fields, phase
 * enumeration, flag and bus structs.
 * assumes a 14-bit instruction word and an 8-bit data path.
 */
package alx_pkg;
	// ==========================================================
	// instruction word layout
	localparam int INSTR_W     = 14;
	localparam int DATA_W      = 8;
	localparam int REG_IDX_W   = 7;
	localparam int DEST_BIT    = 7;
	localparam logic [1:0] OPC_LIT  = 2'h3;
	localparam logic [1:0] OPC_REG  = 2'h0;
	// add literal 111x, and literal 1001, add reg 0111, and reg 0101
	localparam logic [2:0] SUB_ADDLIT = 3'h7;
	localparam logic [3:0] SUB_ANDLIT = 4'h9;
	localparam logic [3:0] SUB_ADDREG = 4'h7;
	localparam logic [3:0] SUB_ANDREG = 4'h5;
	// ==========================================================
	// reset values
	localparam logic [7:0] ACC_RESET  = 8'h00;

	// four phases, gray along the path
	typedef enum logic [1:0] {
		ALX_Q1 = 2'b00,
		ALX_Q2 = 2'b01,
		ALX_Q3 = 2'b11,
		ALX_Q4 = 2'b10
	} alx_phase_e;

	typedef enum logic [2:0] {
		ALX_OP_NONE,
		ALX_OP_ADDLIT,
		ALX_OP_ANDLIT,
		ALX_OP_ADDREG,
		ALX_OP_ANDREG
	} alx_op_e;

	typedef struct packed {
		logic carry;
		logic digitCarry;
		logic zero;
	} alx_flags_s;

	// write to the data register file
	typedef struct packed {
		logic                 en;
		logic [REG_IDX_W-1:0] idx;
		logic [DATA_W-1:0]    data;
	} alx_regwr_s;
endpackage : alx_pkg

//--- rtl/alx_exec.sv
/*
 * four-phase execution datapath for add/and with literal and register.
 * assumes the decoder holds instrWord stable for a whole cycle and the
 * register file answers regRdData combinationally on regRdIdx.
 */
`timescale 1ns/1ps
module alx_exec (
	input  wire logic                          clk,
	input  wire logic                          reset_n,
	input  wire logic [alx_pkg::INSTR_W-1:0]   instrWord,
	input  wire logic [alx_pkg::DATA_W-1:0]    regRdData,
	input  wire logic [alx_pkg::DATA_W-1:0]    flagsIn,
	output logic [alx_pkg::REG_IDX_W-1:0]      regRdIdx,
	output alx_pkg::alx_regwr_s                regWr,
	output logic [alx_pkg::DATA_W-1:0]         accOut,
	output alx_pkg::alx_flags_s                flagsOut,
	output logic                               flagsWe,
	output logic                               instrDone,
	output alx_pkg::alx_phase_e                phaseOut
);
	import alx_pkg::*;

	// ==========================================================
	// phase counter and decode
	alx_phase_e            phase_ff;
	alx_op_e               op_ff;
	logic                  dest_ff;
	logic [REG_IDX_W-1:0]  idx_ff;
	logic [DATA_W-1:0]     opnd_ff;
	logic [DATA_W-1:0]     res_ff;
	alx_flags_s            fl_ff;
	logic [DATA_W-1:0]     acc_ff;
	alx_op_e               nxt_op;
	logic [8:0]            sum;
	logic [4:0]            lowSum;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_ff <= ALX_Q1;
		end else begin
			unique case (phase_ff)
				ALX_Q1: phase_ff <= ALX_Q2;
				ALX_Q2: phase_ff <= ALX_Q3;
				ALX_Q3: phase_ff <= ALX_Q4;
				ALX_Q4: phase_ff <= ALX_Q1;
			endcase
		end
	end

	always_comb begin
		nxt_op = ALX_OP_NONE;
		if (instrWord[13:12] == OPC_LIT) begin
			if (instrWord[11:9] == SUB_ADDLIT)
				nxt_op = ALX_OP_ADDLIT;
			else if (instrWord[11:8] == SUB_ANDLIT)
				nxt_op = ALX_OP_ANDLIT;
		end else if (instrWord[13:12] == OPC_REG) begin
			if (instrWord[11:8] == SUB_ADDREG)
				nxt_op = ALX_OP_ADDREG;
			else if (instrWord[11:8] == SUB_ANDREG)
				nxt_op = ALX_OP_ANDREG;
		end
	end

	// decode in Q1, latch operand fields
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			op_ff   <= ALX_OP_NONE;
			dest_ff <= 1'b0;
			idx_ff  <= '0;
		end else if (phase_ff == ALX_Q1) begin
			op_ff   <= nxt_op;
			dest_ff <= instrWord[DEST_BIT];
			idx_ff  <= instrWord[REG_IDX_W-1:0];
		end
	end

	// read operand in Q2: register data or literal
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			opnd_ff <= '0;
		end else if (phase_ff == ALX_Q2) begin
			if (op_ff == ALX_OP_ADDREG || op_ff == ALX_OP_ANDREG)
				opnd_ff <= regRdData;
			else
				opnd_ff <= instrWord[DATA_W-1:0];
		end
	end

	// ==========================================================
	// process in Q3
	assign sum    = {1'b0, acc_ff} + {1'b0, opnd_ff};
	assign lowSum = {1'b0, acc_ff[3:0]} + {1'b0, opnd_ff[3:0]};

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			res_ff <= '0;
			fl_ff  <= '0;
		end else if (phase_ff == ALX_Q3) begin
			// carry bits pass through untouched for and operations
			fl_ff.carry      <= flagsIn[0];
			fl_ff.digitCarry <= flagsIn[1];
			if (op_ff == ALX_OP_ADDLIT || op_ff == ALX_OP_ADDREG) begin
				res_ff           <= sum[DATA_W-1:0];
				fl_ff.carry      <= sum[DATA_W];
				fl_ff.digitCarry <= lowSum[4];
				fl_ff.zero       <= (sum[DATA_W-1:0] == 8'h00);
			end else begin
				res_ff     <= acc_ff & opnd_ff;
				fl_ff.zero <= ((acc_ff & opnd_ff) == 8'h00);
			end
		end
	end

	// ==========================================================
	// write in Q4
	logic toReg;
	logic active;
	assign active = (op_ff != ALX_OP_NONE);
	assign toReg  = (op_ff == ALX_OP_ADDREG || op_ff == ALX_OP_ANDREG) && dest_ff;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			acc_ff <= ACC_RESET;
		end else if (phase_ff == ALX_Q4 && active && !toReg) begin
			acc_ff <= res_ff;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			regWr     <= '0;
			flagsOut  <= '0;
			flagsWe   <= 1'b0;
			instrDone <= 1'b0;
		end else begin
			regWr.en  <= (phase_ff == ALX_Q4) && toReg;
			regWr.idx <= idx_ff;
			regWr.data <= res_ff;
			flagsWe   <= (phase_ff == ALX_Q4) && active;
			flagsOut  <= fl_ff;
			instrDone <= (phase_ff == ALX_Q4) && active;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			regRdIdx <= '0;
			accOut   <= ACC_RESET;
			phaseOut <= ALX_Q1;
		end else begin
			regRdIdx <= (phase_ff == ALX_Q1) ? instrWord[REG_IDX_W-1:0] : idx_ff;
			accOut   <= (phase_ff == ALX_Q4 && active && !toReg) ? res_ff : acc_ff;
			phaseOut <= phase_ff;
		end
	end

	// ==========================================================
	// checks
	sequence writeQ4;
		phase_ff == ALX_Q4 && active;
	endsequence
	sequence addQ3;
		phase_ff == ALX_Q3 && (op_ff == ALX_OP_ADDLIT || op_ff == ALX_OP_ADDREG);
	endsequence
	sequence litQ4;
		phase_ff == ALX_Q4 && (op_ff == ALX_OP_ADDLIT || op_ff == ALX_OP_ANDLIT);
	endsequence

	phase_order_a: assert property (@(posedge clk) disable iff (!reset_n)
		phase_ff == ALX_Q1 |=> phase_ff == ALX_Q2 ##1 phase_ff == ALX_Q3 ##1 phase_ff == ALX_Q4)
		else $error("phase order broken");
	reg_dest_a: assert property (@(posedge clk) disable iff (!reset_n)
		writeQ4 ##0 toReg |=> regWr.en && regWr.data == $past(res_ff) && $stable(acc_ff))
		else $error("register write wrong");
	acc_dest_a: assert property (@(posedge clk) disable iff (!reset_n)
		writeQ4 ##0 !toReg |=> acc_ff == $past(res_ff) && !regWr.en)
		else $error("accumulator write wrong");
	acc_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		phase_ff != ALX_Q4 |=> $stable(acc_ff))
		else $error("accumulator changed outside write phase");
	add_sum_a: assert property (@(posedge clk) disable iff (!reset_n)
		addQ3
		|=> {fl_ff.carry, res_ff} == {1'b0, $past(acc_ff)} + {1'b0, $past(opnd_ff)})
		else $error("sum or carry wrong");
	and_res_a: assert property (@(posedge clk) disable iff (!reset_n)
		phase_ff == ALX_Q3 && (op_ff == ALX_OP_ANDLIT || op_ff == ALX_OP_ANDREG)
		|=> res_ff == ($past(acc_ff) & $past(opnd_ff)) && fl_ff.carry == $past(flagsIn[0]))
		else $error("and result wrong");
	reg_read_a: assert property (@(posedge clk) disable iff (!reset_n)
		phase_ff == ALX_Q2 && (op_ff == ALX_OP_ADDREG || op_ff == ALX_OP_ANDREG)
		|=> opnd_ff == $past(regRdData))
		else $error("register operand not read");
	zero_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
		phase_ff == ALX_Q4 && op_ff != ALX_OP_NONE |-> fl_ff.zero == (res_ff == 8'h00))
		else $error("zero flag wrong");
	and_digit_keep_a: assert property (@(posedge clk) disable iff (!reset_n)
		phase_ff == ALX_Q3 && op_ff == ALX_OP_ANDREG |=> fl_ff.digitCarry == $past(flagsIn[1]))
		else $error("and changed digit carry");
	// carry into bit 4 recovered from the sum bit, independent of the low adder
	digit_carry_a: assert property (@(posedge clk) disable iff (!reset_n)
		addQ3 |=> fl_ff.digitCarry == (res_ff[4] ^ $past(acc_ff[4]) ^ $past(opnd_ff[4])))
		else $error("digit carry wrong");
	lit_acc_a: assert property (@(posedge clk) disable iff (!reset_n)
		litQ4 |=> acc_ff == $past(res_ff) && accOut == acc_ff && !regWr.en)
		else $error("literal result not in accumulator");
	refused_op_a: assert property (@(posedge clk) disable iff (!reset_n)
		phase_ff == ALX_Q4 && op_ff == ALX_OP_NONE
		|=> !flagsWe && !instrDone && !regWr.en && $stable(acc_ff))
		else $error("unknown opcode had an effect");
	pulse_once_a: assert property (@(posedge clk) disable iff (!reset_n)
		instrDone |=> !instrDone && !flagsWe)
		else $error("completion pulse too long");
	idx_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		phase_ff == ALX_Q2 |-> regRdIdx == idx_ff)
		else $error("read index not presented");
endmodule : alx_exec

//--- testbench/alx_regfile_model.sv
/*
 * behavioural data register file facing the execution datapath.
 * assumes the read is combinational on the index and the write lands
 * at the clock edge that ends the write pulse.
 */
`timescale 1ns/1ps
module alx_regfile_model (
	input  wire logic                        clk,
	input  wire logic [alx_pkg::REG_IDX_W-1:0] rdIdx,
	input  wire alx_pkg::alx_regwr_s         wr,
	output logic [alx_pkg::DATA_W-1:0]       rdData
);
	import alx_pkg::*;
	logic [DATA_W-1:0] mem [128];
	// ==========================================================
	// storage
	// preset pattern so every index reads a distinct value
	initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 11);
	assign rdData = mem[rdIdx];
	always @(posedge clk) begin
		if (wr.en === 1'b1) mem[wr.idx] <= wr.data;
	end
endmodule : alx_regfile_model

//--- testbench/test_add_and_instruction_exec.sv
/*
 * self-checking bench for the add/and execution datapath.
 * assumes one instruction every 4 clocks, decoded at the first edge
 * after reset release, results shown in the cycle after the fourth edge.
 */
`timescale 1ns/1ps
module test_add_and_instruction_exec;
	import alx_pkg::*;
	logic                 clk = 1'b0;
	logic                 reset_n = 1'b0;
	logic [INSTR_W-1:0]   instrWord = '0;
	logic [DATA_W-1:0]    flagsIn = '0;
	logic [DATA_W-1:0]    regRdData, accOut, expAcc = ACC_RESET, expData;
	logic [REG_IDX_W-1:0] regRdIdx, expIdx = '0;
	alx_phase_e           expPhase = ALX_Q1;
	alx_regwr_s           regWr;
	alx_flags_s           flagsOut, expFlags;
	logic                 flagsWe, instrDone, expWe = 1'b0, expRegEn = 1'b0;
	alx_phase_e           phaseOut;
	int                   nMismatch = 0, checksDone = 0, seed = 99;
	logic [7:0]           mirror [128];
	logic [13:0]          base [4] = '{14'h3e00, 14'h3900, 14'h0700, 14'h0500};
	always #10 clk = ~clk;
	alx_exec u_alx_exec (.clk(clk), .reset_n(reset_n), .instrWord(instrWord),
		.regRdData(regRdData), .flagsIn(flagsIn), .regRdIdx(regRdIdx), .regWr(regWr),
		.accOut(accOut), .flagsOut(flagsOut), .flagsWe(flagsWe), .instrDone(instrDone),
		.phaseOut(phaseOut));
	alx_regfile_model u_alx_regfile_model (.clk(clk), .rdIdx(regRdIdx), .wr(regWr),
		.rdData(regRdData));
	// ==========================================================
	// tasks
	task check(input logic [15:0] seen, input logic [15:0] exp);
		checksDone++;
		if (seen !== exp) begin
			nMismatch++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// checks the previous instruction while the new one decodes,
	// since results appear only at the edge where the next word is driven, before it is taken
	// returns {carry, digit carry, zero, result}; and keeps incoming carry bits
	function automatic logic [10:0] predict(input logic [7:0] acc, input logic [7:0] opnd,
		input logic isAdd, input logic [7:0] f);
		logic [8:0] s;
		logic [4:0] l;
		logic [7:0] r;
		s = {1'b0, acc} + {1'b0, opnd};
		l = {1'b0, acc[3:0]} + {1'b0, opnd[3:0]};
		r = isAdd ? s[7:0] : (acc & opnd);
		return isAdd ? {s[8], l[4], r == 8'h00, r} : {f[0], f[1], r == 8'h00, r};
	endfunction : predict
	task exec(input logic [13:0] w);
		logic [7:0] opnd, res, f;
		logic       isAdd, isReg, valid;
		f = 8'($random(seed));
		instrWord <= w;
		flagsIn <= f;
		@(negedge clk);
		check(phaseOut, expPhase);
		check(regRdIdx, expIdx);
		check(flagsWe, expWe);
		check(instrDone, expWe);
		check(accOut, expAcc);
		check(regWr.en, expRegEn);
		if (expWe) check(flagsOut, expFlags);
		if (expRegEn) check({regWr.idx, regWr.data}, {expIdx, expData});
		if (expRegEn) mirror[expIdx] = expData;
		isReg = (w[13:12] == OPC_REG);
		opnd = isReg ? mirror[w[6:0]] : w[7:0];
		valid = 1'b1;
		isAdd = 1'b0;
		if (w[13:12] == OPC_LIT && w[11:9] == SUB_ADDLIT) isAdd = 1'b1;
		else if (w[13:12] == OPC_LIT && w[11:8] == SUB_ANDLIT) isAdd = 1'b0;
		else if (isReg && w[11:8] == SUB_ADDREG) isAdd = 1'b1;
		else if (!(isReg && w[11:8] == SUB_ANDREG)) valid = 1'b0;
		{expFlags, res} = predict(expAcc, opnd, isAdd, f);
		expPhase = ALX_Q4;
		expWe = valid;
		expRegEn = valid && isReg && w[DEST_BIT];
		expIdx = w[6:0];
		expData = res;
		if (valid && !(isReg && w[DEST_BIT])) expAcc = res;
		repeat (4) @(posedge clk);
	endtask : exec
	task conclude;
		if (nMismatch == 0 && checksDone > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	// ==========================================================
	// sequence
	initial begin
		for (int i = 0; i < 128; i++) mirror[i] = 8'(i * 37 + 11);
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		// all four ops at 0xff (literal 0xff, or index 127 with register target), then add wraps to zero
		foreach (base[i]) exec(base[i] | 14'h00ff);
		exec(14'h3f01);
		exec(14'h3e15);
		exec(14'h395f);
		exec(14'h077f);
		exec(14'h05ff);
		exec(14'h0780);
		exec(14'h3900);
		exec(14'h3a00);
		for (int n = 0; n < 60; n++) begin
			if (n % 5 == 4) exec(14'($random(seed)));
			else exec(base[$unsigned($random(seed)) % 4] | 14'($random(seed) & 255));
		end
		exec(14'h0000);
		conclude();
	end
endmodule : test_add_and_instruction_exec
